// ==== ptp_defs.svh ====
// Constants for the pulse train positioner
`ifndef PTP_DEFS_SVH
`define PTP_DEFS_SVH
`define PTP_CLK_HZ 100000000
`define PTP_MIN_NUM 500
`define PTP_REL_MAX 999999
`define PTP_FREQ_MAX 100000
`define PTP_PULSE_HIGH 8'h32
`define PTP_REG_POS0_HI 4'h0
`define PTP_REG_POS0_LO 4'h1
`define PTP_REG_POS1_HI 4'h2
`define PTP_REG_POS1_LO 4'h3
`define PTP_REG_MAXSPD_A 4'h4
`define PTP_REG_MAXSPD_B 4'h5
`define PTP_REG_ACCEL_MS 4'h6
`define PTP_REG_FLAGS 4'h7
`define PTP_REG_STATUS 4'h8
`define PTP_REG_FMIN 4'h9
`define PTP_FLAG_CTRL0 0
`define PTP_FLAG_CTRL1 1
`define PTP_FLAG_CLR_EN 2
`define PTP_CLR_LEN 16'h07d0
`endif

// ==== ptp_pkg.sv ====
// Types for the pulse train positioner
package ptp_pkg;
	typedef enum logic [1:0] {PTP_MODE_ORIGIN, PTP_MODE_VSPEED, PTP_MODE_REL} ptp_mode_t;
	typedef struct packed {
		logic enable;
		logic chan;
		ptp_mode_t mode;
		logic [31:0] value;
		logic [31:0] freq;
		logic [31:0] crawl;
		logic prox;
	} ptp_cmd_t;
endpackage

// ==== ptp_isqrt.sv ====
// Iterative integer square root
`timescale 1ns/100ps
module ptp_isqrt (
	input wire logic i_clk,
	input wire logic i_resetn,
	input wire logic i_start,
	input wire logic [31:0] i_value,
	output logic o_done,
	output logic [15:0] o_root
);
	logic [31:0] rem_r, rem_nxt;
	logic [15:0] root_r, root_nxt;
	logic [4:0] cnt_r, cnt_nxt;
	logic busy_r, busy_nxt, done_r, done_nxt;
	logic [15:0] trial;
	always_comb begin
		rem_nxt = rem_r;
		root_nxt = root_r;
		cnt_nxt = cnt_r;
		busy_nxt = busy_r;
		done_nxt = 1'b0;
		trial = root_r | (16'h1 << cnt_r[3:0]);
		if (i_start) begin
			rem_nxt = i_value;
			root_nxt = 16'h0;
			cnt_nxt = 5'hf;
			busy_nxt = 1'b1;
		end else if (busy_r) begin
			if ({16'h0, trial} * {16'h0, trial} <= {32'h0, rem_r})
				root_nxt = trial;
			if (cnt_r == 5'h0) begin
				busy_nxt = 1'b0;
				done_nxt = 1'b1;
			end else begin
				cnt_nxt = cnt_r - 5'h1;
			end
		end
	end
	always_ff @(posedge i_clk) begin
		if (!i_resetn) begin
			rem_r <= 32'h0;
			root_r <= 16'h0;
			cnt_r <= 5'h0;
			busy_r <= 1'b0;
			done_r <= 1'b0;
		end else begin
			rem_r <= rem_nxt;
			root_r <= root_nxt;
			cnt_r <= cnt_nxt;
			busy_r <= busy_nxt;
			done_r <= done_nxt;
		end
	end
	assign o_done = done_r;
	assign o_root = root_r;
endmodule

// ==== ptp_top.sv ====
// Pulse train positioner: origin return, variable speed, relative move
//
// Summary of operation
// - Origin return runs at start speed, then crawl speed once proximity is active.
// - With clear enable set, clear pulses go out on general outputs 2 and 3.
// - Each origin return pulse decrements the channel position.
// - Minimum frequency is square root of max speed times 500 over accel ms.
// - Max speed comes from two words, accel time from its own setting.
// - Never output below minimum; no pulses when max speed under minimum.
// - Variable speed takes signed frequency; sign sets direction output.
// - Variable speed accepts a new frequency during output.
// - Variable speed starts and stops without ramping.
// - Variable speed stops at once when enable drops.
// - Busy monitor set blocks variable speed restart after enable drop.
// - Relative move emits signed count within 999999; sign sets direction.
// - Each channel keeps a 32-bit position as two words.
// - Relative move decrements position while direction low, else increments.
// - Relative move operand changes during a move wait for the next start.
// - Enable drop in relative move decelerates to stop, no completion flag.
// - Output control flag set blocks relative move restart after enable drop.
`timescale 1ns/100ps
`include "ptp_defs.svh"
module ptp_top import ptp_pkg::*; (
	input wire logic i_clk,
	input wire logic i_resetn,
	input wire ptp_cmd_t i_cmd,
	input wire logic [3:0] i_addr,
	input wire logic [15:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	output logic [15:0] o_rdata,
	output logic o_pulse0,
	output logic o_pulse1,
	output logic o_dir,
	output logic o_clear0,
	output logic o_clear1,
	output logic o_busy0,
	output logic o_busy1,
	output logic o_done
);
	typedef enum logic [1:0] {ST_IDLE, ST_RUN, ST_DECEL, ST_BLOCK} ptp_state_t;
	localparam logic [31:0] CLK_HZ = 32'(`PTP_CLK_HZ);
	ptp_state_t st_r, st_nxt;
	ptp_cmd_t act_r, act_nxt;
	logic [31:0] pos0_r, pos0_nxt, pos1_r, pos1_nxt;
	logic [15:0] spd_a_r, spd_a_nxt, spd_b_r, spd_b_nxt, acc_r, acc_nxt;
	logic [2:0] flags_r, flags_nxt;
	logic [15:0] rdata_r, rdata_nxt;
	logic [31:0] left_r, left_nxt, div_r, div_nxt;
	logic busy0_r, busy0_nxt, busy1_r, busy1_nxt;
	logic [7:0] hi_r, hi_nxt;
	logic pulse0_r, pulse0_nxt, pulse1_r, pulse1_nxt, dir_r, dir_nxt;
	logic clr0_r, clr0_nxt, clr1_r, clr1_nxt, done_r, done_nxt;
	logic [15:0] clrcnt_r, clrcnt_nxt;
	logic en_d_r;
	logic [15:0] fmin_r, fmin_nxt;
	logic [31:0] quot;
	logic sq_done;
	logic [15:0] sq_root;
	logic sq_start_r;
	logic [31:0] fmax, target, per, abs_val;
	logic fire;
	// Two-word max speed feeds the minimum frequency and the start check
	// speed words
	assign fmax = {spd_a_r, spd_b_r};
	assign abs_val = i_cmd.value[31] ? -i_cmd.value : i_cmd.value;
	assign quot = (acc_r == 16'h0) ? 32'h0 : 32'((64'(fmax) * `PTP_MIN_NUM) / acc_r);
	ptp_isqrt u_sqrt (
		.i_clk(i_clk),
		.i_resetn(i_resetn),
		.i_start(sq_start_r),
		.i_value(quot),
		.o_done(sq_done),
		.o_root(sq_root)
	);
	always_comb begin
		// Frequency target by mode
		target = act_r.freq;
		unique case (act_r.mode)
			PTP_MODE_ORIGIN: target = i_cmd.prox ? act_r.crawl : act_r.freq;
			PTP_MODE_VSPEED: target = abs_val;
			PTP_MODE_REL: target = act_r.freq;
			default: target = act_r.freq;
		endcase
		if (target < {16'h0, fmin_r})
			target = {16'h0, fmin_r};
		if (st_r == ST_DECEL)
			target = {16'h0, fmin_r};
		per = (target == 32'h0) ? 32'hffffffff : CLK_HZ / target;
	end
	assign fire = (st_r == ST_RUN || st_r == ST_DECEL) && (div_r + 32'h1 >= per);
	always_comb begin
		st_nxt = st_r;
		act_nxt = act_r;
		pos0_nxt = pos0_r;
		pos1_nxt = pos1_r;
		spd_a_nxt = spd_a_r;
		spd_b_nxt = spd_b_r;
		acc_nxt = acc_r;
		flags_nxt = flags_r;
		rdata_nxt = 16'h0;
		left_nxt = left_r;
		div_nxt = div_r;
		hi_nxt = (hi_r != 8'h0) ? hi_r - 8'h1 : 8'h0;
		pulse0_nxt = 1'b0;
		pulse1_nxt = 1'b0;
		dir_nxt = dir_r;
		clr0_nxt = 1'b0;
		clr1_nxt = 1'b0;
		clrcnt_nxt = (clrcnt_r != 16'h0) ? clrcnt_r - 16'h1 : 16'h0;
		done_nxt = done_r;
		fmin_nxt = sq_done ? sq_root : fmin_r;
		if (i_wr) begin
			unique case (i_addr)
				`PTP_REG_POS0_HI: pos0_nxt[31:16] = i_wdata;
				`PTP_REG_POS0_LO: pos0_nxt[15:0] = i_wdata;
				`PTP_REG_POS1_HI: pos1_nxt[31:16] = i_wdata;
				`PTP_REG_POS1_LO: pos1_nxt[15:0] = i_wdata;
				`PTP_REG_MAXSPD_A: spd_a_nxt = i_wdata;
				`PTP_REG_MAXSPD_B: spd_b_nxt = i_wdata;
				`PTP_REG_ACCEL_MS: acc_nxt = i_wdata;
				`PTP_REG_FLAGS: flags_nxt = i_wdata[2:0];
				default: ;
			endcase
		end
		if (i_rd) begin
			unique case (i_addr)
				`PTP_REG_POS0_HI: rdata_nxt = pos0_r[31:16];
				`PTP_REG_POS0_LO: rdata_nxt = pos0_r[15:0];
				`PTP_REG_POS1_HI: rdata_nxt = pos1_r[31:16];
				`PTP_REG_POS1_LO: rdata_nxt = pos1_r[15:0];
				`PTP_REG_MAXSPD_A: rdata_nxt = spd_a_r;
				`PTP_REG_MAXSPD_B: rdata_nxt = spd_b_r;
				`PTP_REG_ACCEL_MS: rdata_nxt = acc_r;
				`PTP_REG_FLAGS: rdata_nxt = {13'h0, flags_r};
				`PTP_REG_STATUS: rdata_nxt = {11'h0, done_r, dir_r, st_r, act_r.chan};
				`PTP_REG_FMIN: rdata_nxt = fmin_r;
				default: rdata_nxt = 16'h0;
			endcase
		end
		unique case (st_r)
			ST_IDLE: begin
				if (i_cmd.enable && !en_d_r) begin
					act_nxt = i_cmd;
					left_nxt = (abs_val > `PTP_REL_MAX) ? 32'(`PTP_REL_MAX) : abs_val;
					dir_nxt = !i_cmd.value[31];
					if (i_cmd.mode == PTP_MODE_ORIGIN)
						dir_nxt = 1'b0;
					div_nxt = 32'h0;
					done_nxt = 1'b0;
					if (fmax >= {16'h0, fmin_r} && fmin_r != 16'h0)
						st_nxt = ST_RUN;
				end
			end
			ST_RUN: begin
				// Direction never moves on a pulse rising edge
				if (act_r.mode == PTP_MODE_VSPEED && !fire)
					dir_nxt = !i_cmd.value[31];
				if (!i_cmd.enable) begin
					if (act_r.mode == PTP_MODE_VSPEED)
						st_nxt = ST_BLOCK;
					else if (act_r.mode == PTP_MODE_REL)
						st_nxt = ST_DECEL;
					else
						st_nxt = ST_BLOCK;
				end
			end
			ST_DECEL: begin
				if (fire)
					st_nxt = ST_BLOCK;
			end
			ST_BLOCK: begin
				if (!(act_r.mode == PTP_MODE_VSPEED && (act_r.chan ? busy1_r : busy0_r))
					&& !(act_r.mode == PTP_MODE_REL && flags_r[act_r.chan]))
					st_nxt = ST_IDLE;
			end
		endcase
		if (fire) begin
			div_nxt = 32'h0;
			hi_nxt = `PTP_PULSE_HIGH;
			if (act_r.chan)
				pulse1_nxt = 1'b1;
			else
				pulse0_nxt = 1'b1;
			if (act_r.chan)
				pos1_nxt = dir_r ? pos1_r + 32'h1 : pos1_r - 32'h1;
			else
				pos0_nxt = dir_r ? pos0_r + 32'h1 : pos0_r - 32'h1;
			if (act_r.mode == PTP_MODE_REL && st_r == ST_RUN) begin
				left_nxt = left_r - 32'h1;
				if (left_r <= 32'h1) begin
					st_nxt = ST_BLOCK;
					done_nxt = 1'b1;
				end
			end
		end else if (st_r == ST_RUN || st_r == ST_DECEL) begin
			div_nxt = div_r + 32'h1;
		end
		if (st_r == ST_RUN && act_r.mode == PTP_MODE_REL && left_r == 32'h0) begin
			st_nxt = ST_BLOCK;
			done_nxt = 1'b1;
		end
		if (hi_r != 8'h0) begin
			pulse0_nxt = !act_r.chan;
			pulse1_nxt = act_r.chan;
		end
		if (st_r == ST_RUN && act_r.mode == PTP_MODE_ORIGIN && !i_cmd.enable
			&& flags_r[`PTP_FLAG_CLR_EN])
			clrcnt_nxt = `PTP_CLR_LEN;
		if (clrcnt_r != 16'h0) begin
			clr0_nxt = !act_r.chan;
			clr1_nxt = act_r.chan;
		end
		busy0_nxt = ((st_nxt == ST_RUN || st_nxt == ST_DECEL) && !act_nxt.chan)
			|| ((st_r == ST_RUN || st_r == ST_DECEL) && !act_r.chan);
		busy1_nxt = ((st_nxt == ST_RUN || st_nxt == ST_DECEL) && act_nxt.chan)
			|| ((st_r == ST_RUN || st_r == ST_DECEL) && act_r.chan);
	end
	always_ff @(posedge i_clk) begin
		if (!i_resetn) begin
			st_r <= ST_IDLE;
			act_r <= '0;
			pos0_r <= 32'h0;
			pos1_r <= 32'h0;
			spd_a_r <= 16'h0;
			spd_b_r <= 16'h0;
			acc_r <= 16'h0;
			flags_r <= 3'h0;
			rdata_r <= 16'h0;
			left_r <= 32'h0;
			busy0_r <= 1'b0;
			busy1_r <= 1'b0;
			div_r <= 32'h0;
			hi_r <= 8'h0;
			pulse0_r <= 1'b0;
			pulse1_r <= 1'b0;
			dir_r <= 1'b0;
			clr0_r <= 1'b0;
			clr1_r <= 1'b0;
			clrcnt_r <= 16'h0;
			done_r <= 1'b0;
			en_d_r <= 1'b0;
			fmin_r <= 16'h0;
			sq_start_r <= 1'b0;
		end else begin
			st_r <= st_nxt;
			act_r <= act_nxt;
			pos0_r <= pos0_nxt;
			pos1_r <= pos1_nxt;
			spd_a_r <= spd_a_nxt;
			spd_b_r <= spd_b_nxt;
			acc_r <= acc_nxt;
			flags_r <= flags_nxt;
			rdata_r <= rdata_nxt;
			left_r <= left_nxt;
			busy0_r <= busy0_nxt;
			busy1_r <= busy1_nxt;
			div_r <= div_nxt;
			hi_r <= hi_nxt;
			pulse0_r <= pulse0_nxt;
			pulse1_r <= pulse1_nxt;
			dir_r <= dir_nxt;
			clr0_r <= clr0_nxt;
			clr1_r <= clr1_nxt;
			clrcnt_r <= clrcnt_nxt;
			done_r <= done_nxt;
			en_d_r <= i_cmd.enable;
			fmin_r <= fmin_nxt;
			sq_start_r <= i_wr;
		end
	end
	assign o_rdata = rdata_r;
	assign o_pulse0 = pulse0_r;
	assign o_pulse1 = pulse1_r;
	assign o_dir = dir_r;
	assign o_clear0 = clr0_r;
	assign o_clear1 = clr1_r;
	assign o_busy0 = busy0_r;
	assign o_busy1 = busy1_r;
	assign o_done = done_r;
endmodule

// ==== ptp_drive_model.sv ====
// Drive model: counts step pulses into a signed position
`timescale 1ns/100ps
module ptp_drive_model (
	input wire logic i_clk,
	input wire logic i_pulse,
	input wire logic i_dir,
	output logic signed [31:0] o_pos
);
	logic last_r = 1'b0;
	logic signed [31:0] pos_r = 32'sh0;
	always @(posedge i_clk) begin
		last_r <= i_pulse;
		if (i_pulse && !last_r)
			pos_r <= pos_r + (i_dir ? 32'sh1 : -32'sh1);
	end
	assign o_pos = pos_r;
endmodule

// ==== ptp_properties.sv ====
// Port checker for the pulse train positioner
`timescale 1ns/100ps
module ptp_properties import ptp_pkg::*; (
	input wire logic i_clk,
	input wire logic i_resetn,
	input wire ptp_cmd_t i_cmd,
	input wire logic i_rd,
	input wire logic [15:0] o_rdata,
	input wire logic o_pulse0,
	input wire logic o_pulse1,
	input wire logic o_dir,
	input wire logic o_clear0,
	input wire logic o_busy0,
	input wire logic o_busy1,
	input wire logic o_done
);
	logic [15:0] clr_cnt_r;
	logic [15:0] clr_cnt_nxt;
	always_comb clr_cnt_nxt = o_clear0 ? clr_cnt_r + 16'h1 : 16'h0;
	always_ff @(posedge i_clk) clr_cnt_r <= i_resetn ? clr_cnt_nxt : 16'h0;
	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_resetn);
	sequence s_vs_drop;
		$fell(i_cmd.enable) && i_cmd.mode == PTP_MODE_VSPEED;
	endsequence
	sequence s_idle_soon;
		##[1:3] !(o_busy0 || o_busy1);
	endsequence
	rdata_idle_a: assert property (
		!$past(i_rd) |-> o_rdata == 16'h0) else $error("read data outside read slot");
	pulse0_busy_a: assert property (
		$rose(o_pulse0) |-> $past(o_busy0)) else $error("pulse 0 while idle");
	pulse1_busy_a: assert property (
		$rose(o_pulse1) |-> $past(o_busy1)) else $error("pulse 1 while idle");
	pulse_width_a: assert property (
		$rose(o_pulse0) |=> o_pulse0 [*8]) else $error("pulse too short");
	dir_steady_a: assert property (
		$rose(o_pulse0) || $rose(o_pulse1) |-> $stable(o_dir)) else $error("dir moved at pulse");
	clear_len_a: assert property (
		$fell(o_clear0) |-> clr_cnt_r == 16'h07d0) else $error("clear length wrong");
	clear_cause_a: assert property (
		$rose(o_clear0) |-> !i_cmd.enable) else $error("clear while enabled");
	vs_stop_a: assert property (
		s_vs_drop |-> s_idle_soon) else $error("variable speed kept running");
	done_cause_a: assert property (
		$rose(o_done) |-> $past(o_busy0 || o_busy1)) else $error("done without move");
endmodule
bind ptp_top ptp_properties u_chk (.i_clk, .i_resetn, .i_cmd, .i_rd, .o_rdata, .o_pulse0,
	.o_pulse1, .o_dir, .o_clear0, .o_busy0, .o_busy1, .o_done);

// ==== ptp_top_tb.sv ====
// Self-checking bench for the pulse train positioner
`timescale 1ns/100ps
`include "ptp_defs.svh"
module ptp_top_tb import ptp_pkg::*; ;
	logic i_clk = 1'b0, i_resetn = 1'b0, i_wr = 1'b0, i_rd = 1'b0;
	logic [3:0] i_addr = 4'h0;
	logic [15:0] i_wdata = 16'h0, o_rdata;
	logic o_pulse0, o_pulse1, o_dir, o_clear0, o_clear1, o_busy0, o_busy1, o_done;
	ptp_cmd_t i_cmd = '0;
	logic signed [31:0] pos0, pos1;
	int fails = 0, comparisons = 0;
	ptp_top i_dut (.i_clk, .i_resetn, .i_cmd, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata,
		.o_pulse0, .o_pulse1, .o_dir, .o_clear0, .o_clear1, .o_busy0, .o_busy1, .o_done);
	ptp_drive_model i_drv0 (.i_clk, .i_pulse(o_pulse0), .i_dir(o_dir), .o_pos(pos0));
	ptp_drive_model i_drv1 (.i_clk, .i_pulse(o_pulse1), .i_dir(o_dir), .o_pos(pos1));
	initial forever #5 i_clk = ~i_clk;
	task automatic tally_and_finish();
		$display("Checks %0d, mismatches %0d", comparisons, fails);
		if (fails == 0 && comparisons > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task automatic chk(string nm, logic [31:0] exp, logic [31:0] got);
		comparisons++;
		if (got !== exp) begin
			fails++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic tick(int n);
		repeat (n) @(posedge i_clk);
	endtask
	task automatic wr(logic [3:0] a, logic [15:0] d);
		@(posedge i_clk);
		i_addr <= a;
		i_wdata <= d;
		i_wr <= 1'b1;
		@(posedge i_clk);
		i_wr <= 1'b0;
	endtask
	task automatic rd(logic [3:0] a, output logic [15:0] d);
		@(posedge i_clk);
		i_addr <= a;
		i_rd <= 1'b1;
		@(posedge i_clk);
		i_rd <= 1'b0;
		#1 d = o_rdata;
	endtask
	task automatic chk_pos(logic [3:0] a, logic [31:0] exp);
		logic [15:0] hi, lo;
		rd(a, hi);
		rd(a + 4'h1, lo);
		chk("position", exp, {hi, lo});
	endtask
	task automatic run(logic ch, ptp_mode_t m, logic [31:0] v);
		@(posedge i_clk);
		i_cmd.chan <= ch;
		i_cmd.mode <= m;
		i_cmd.value <= v;
		i_cmd.enable <= 1'b1;
	endtask
	task automatic halt();
		@(posedge i_clk);
		i_cmd.enable <= 1'b0;
	endtask
	task automatic wait_idle();
		int k;
		tick(5);
		for (k = 0; k < 20000 && (o_busy0 || o_busy1); k++)
			@(posedge i_clk);
		if (k == 20000) begin
			fails++;
			tally_and_finish();
		end else begin
			tick(2);
		end
	endtask
	task automatic s_regs();
		logic [15:0] d;
		rd(`PTP_REG_FMIN, d);
		chk("fmin reset", 32'h0, {16'h0, d});
		rd(4'hf, d);
		chk("unmapped", 32'h0, {16'h0, d});
		wr(`PTP_REG_MAXSPD_A, 16'h0001);
		wr(`PTP_REG_MAXSPD_B, 16'h86a0);
		wr(`PTP_REG_ACCEL_MS, 16'h01f4);
		tick(20);
		rd(`PTP_REG_FMIN, d);
		chk("fmin", 32'h13c, {16'h0, d});
	endtask
	task automatic s_rel();
		logic [15:0] d;
		run(1'b0, PTP_MODE_REL, 32'h5);
		tick(200);
		i_cmd.value <= 32'h9;
		wait_idle();
		chk("done", 32'h1, {31'h0, o_done});
		chk("dir up", 32'h1, {31'h0, o_dir});
		chk("pulses", 32'h5, pos0);
		chk_pos(`PTP_REG_POS0_HI, 32'h5);
		halt();
		run(1'b0, PTP_MODE_REL, 32'hfffffffd);
		wait_idle();
		chk("dir down", 32'h0, {31'h0, o_dir});
		chk_pos(`PTP_REG_POS0_HI, 32'h2);
		wr(`PTP_REG_ACCEL_MS, 16'h0001);
		wr(`PTP_REG_FLAGS, 16'h0001);
		tick(20);
		rd(`PTP_REG_FMIN, d);
		chk("fmin fast", 32'h1b9f, {16'h0, d});
		halt();
		run(1'b0, PTP_MODE_REL, 32'h64);
		tick(2500);
		halt();
		wait_idle();
		chk("done on drop", 32'h0, {31'h0, o_done});
		run(1'b0, PTP_MODE_REL, 32'h1);
		tick(50);
		chk("held off", 32'h0, {31'h0, o_busy0});
		halt();
		wr(`PTP_REG_FLAGS, 16'h0000);
		run(1'b0, PTP_MODE_REL, 32'h1);
		tick(50);
		chk("released", 32'h1, {31'h0, o_busy0});
		wait_idle();
		wr(`PTP_REG_ACCEL_MS, 16'h01f4);
		tick(20);
	endtask
	task automatic s_vs();
		halt();
		run(1'b1, PTP_MODE_VSPEED, 32'hfffe7960);
		tick(3000);
		chk("dir neg", 32'h0, {31'h0, o_dir});
		chk("no ramp", 32'h1, {31'h0, pos1 < 0});
		i_cmd.value <= 32'h000186a0;
		tick(3500);
		chk("dir pos", 32'h1, {31'h0, o_dir});
		halt();
		tick(3);
		chk("stopped", 32'h0, {31'h0, o_busy1});
	endtask
	task automatic s_org();
		int p;
		wr(`PTP_REG_FLAGS, 16'h0004);
		p = pos0;
		run(1'b0, PTP_MODE_ORIGIN, 32'h0);
		tick(3500);
		chk("origin down", 32'h1, {31'h0, pos0 < p});
		i_cmd.prox <= 1'b1;
		tick(100);
		p = pos0;
		tick(40000);
		// Crawl at 5 kHz gives about two steps here
		chk("crawl", 32'h1, {31'h0, (p - pos0) inside {[1:3]}});
		halt();
		tick(5);
		chk("clear", 32'h1, {31'h0, o_clear0});
		chk("clear1 quiet", 32'h0, {31'h0, o_clear1});
		chk_pos(`PTP_REG_POS0_HI, pos0);
	endtask
	initial begin
		i_cmd.freq = 32'h000186a0;
		i_cmd.crawl = 32'h00001388;
		tick(20);
		i_resetn <= 1'b1;
		s_regs();
		s_rel();
		s_vs();
		s_org();
		tally_and_finish();
	end
endmodule
